// file: core/pts_pkg.sv
/*
 * constants for the position-triggered timing output block: register map,
 * signal type codes, reset values and pulse-width cycle counts.
 * assumes a 200 MHz system clock and a 32-bit AXI4-Lite register bus.
 */
`default_nettype none
package pts_pkg;
    localparam int NCH      = 16;              // motor channels
    localparam int NPORT    = 4;               // timing output ports
    localparam int CLK_NS   = 5;               // clock period in ns
    // register byte offsets
    localparam logic [7:0] A_CH_SEL  = 8'h00;  // channel addressed below
    localparam logic [7:0] A_CMD     = 8'h04;  // bit0 arm, bit1 disarm
    localparam logic [7:0] A_TYPE    = 8'h08;  // signal type of channel
    localparam logic [7:0] A_START   = 8'h0C;  // start point
    localparam logic [7:0] A_END     = 8'h10;  // end point
    localparam logic [7:0] A_INTV    = 8'h14;  // pulse interval
    localparam logic [7:0] A_PREP    = 8'h18;  // preparation state (ro)
    localparam logic [7:0] A_ROUTE   = 8'h1C;  // routing mode
    localparam logic [7:0] A_ASSIGN  = 8'h20;  // port channel assignment
    // field positions
    localparam int CMD_ARM    = 0;
    localparam int CMD_DISARM = 1;
    localparam int RT_FIXED   = 0;             // routing request bit
    localparam int RT_EFF     = 1;             // routing in force (ro)
    // signal type codes
    localparam logic [3:0] TY_NONE  = 4'h0;
    localparam logic [3:0] TY_GATE  = 4'h1;
    localparam logic [3:0] TY_P200N = 4'h2;
    localparam logic [3:0] TY_P10U  = 4'h3;
    localparam logic [3:0] TY_P100U = 4'h4;
    localparam logic [3:0] TY_P1M   = 4'h5;
    localparam logic [3:0] TY_MLVL  = 4'h6;
    localparam logic [3:0] TY_M1U   = 4'h7;
    localparam logic [3:0] TY_M10U  = 4'h8;
    localparam logic [3:0] TY_M100U = 4'h9;
    localparam logic [3:0] TY_M1M   = 4'hA;
    // preparation state answers
    localparam logic [2:0] PS_NO    = 3'h0;
    localparam logic [2:0] PS_YES   = 3'h1;
    localparam logic [2:0] PS_LOW   = 3'h2;
    localparam logic [2:0] PS_HIGH  = 3'h3;
    localparam logic [2:0] PS_PULSE = 3'h4;
    // reset values
    localparam logic [31:0] RST_START  = 32'h0000_03E8;  // +1000
    localparam logic [31:0] RST_END    = 32'h0000_2710;  // +10000
    localparam logic [31:0] RST_INTV   = 32'h0000_00C8;  // 200
    localparam logic [15:0] RST_ASSIGN = 16'h3210;
    // pulse widths in ns and in clock cycles
    localparam int W200N_NS = 200;
    localparam int W1U_NS   = 1000;
    localparam int W10U_NS  = 10000;
    localparam int W100U_NS = 100000;
    localparam int W1M_NS   = 1000000;
    localparam int W200N_CYC = W200N_NS / CLK_NS;
    localparam int W1U_CYC   = W1U_NS / CLK_NS;
    localparam int W10U_CYC  = W10U_NS / CLK_NS;
    localparam int W100U_CYC = W100U_NS / CLK_NS;
    localparam int W1M_CYC   = W1M_NS / CLK_NS;
    localparam int CW        = 18;             // width counter bits
endpackage
`default_nettype wire

// file: core/pts_oneshot.sv
/*
 * retriggerable one-shot: holds its output high for a loaded number of
 * clock cycles. assumes the load count is at least one.
 */
`timescale 1ns/100ps
`default_nettype none
module pts_oneshot #(
    parameter int CW = 18                      // counter width
) (
    input  wire logic          clk_i,          // system clock
    input  wire logic          rst_n_i,        // synchronous, active low
    input  wire logic          load_i,         // start a pulse
    input  wire logic [CW-1:0] cnt_i,          // pulse width in cycles
    output var  logic          busy_o          // pulse in progress
);
    logic [CW-1:0] cnt;                        // cycles left

    // load restarts the pulse; count down to the last cycle
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt    <= '0;
            busy_o <= 1'b0;
        end else if (load_i) begin
            cnt    <= cnt_i;
            busy_o <= 1'b1;
        end else if (cnt > 1) begin
            cnt <= cnt - 1'b1;
        end else begin
            cnt    <= '0;
            busy_o <= 1'b0;
        end
    end

    a_width_end: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $fell(busy_o) |-> $past(cnt) <= 1 && !$past(load_i))
        else $error("one-shot ended before its count ran out");
    a_load_busy: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        load_i && cnt_i > 1 |=> busy_o ##1 busy_o)
        else $error("one-shot pulse shorter than two cycles");
endmodule // pts_oneshot
`default_nettype wire

// file: core/pts_timing_out.sv
/*
 * position-triggered timing output for sixteen motor channels, four
 * output ports, AXI4-Lite register slave.
 * assumes motor positions and busy flags are synchronous to SYS_CLK_I.
 */
`timescale 1ns/100ps
`default_nettype none
module pts_timing_out import pts_pkg::*; #(
    parameter int P100U_CYC = W100U_CYC,       // 100 us width in cycles
    parameter int P1M_CYC   = W1M_CYC          // 1 ms width in cycles
) (
    input  wire logic              SYS_CLK_I,
    input  wire logic              RESETN_I,
    input  wire logic [NCH*32-1:0] MOTOR_POS_I,   // signed positions
    input  wire logic [NCH-1:0]    MOTOR_BUSY_I,  // motor moving
    input  wire logic [15:0]       DISP_CH_I,     // channel at each row
    output var  logic [NPORT-1:0]  TIMING_PORT_O, // timing outputs
    input  wire logic              S_AXI_AWVALID,
    output var  logic              S_AXI_AWREADY,
    input  wire logic [7:0]        S_AXI_AWADDR,
    input  wire logic              S_AXI_WVALID,
    output var  logic              S_AXI_WREADY,
    input  wire logic [31:0]       S_AXI_WDATA,
    input  wire logic [3:0]        S_AXI_WSTRB,
    output var  logic              S_AXI_BVALID,
    input  wire logic              S_AXI_BREADY,
    output var  logic [1:0]        S_AXI_BRESP,
    input  wire logic              S_AXI_ARVALID,
    output var  logic              S_AXI_ARREADY,
    input  wire logic [7:0]        S_AXI_ARADDR,
    output var  logic              S_AXI_RVALID,
    input  wire logic              S_AXI_RREADY,
    output var  logic [31:0]       S_AXI_RDATA,
    output var  logic [1:0]        S_AXI_RRESP
);
    // width count for a signal type
    function automatic logic [CW-1:0] width_of(input logic [3:0] t);
        case (t)
            TY_P200N: width_of = CW'(W200N_CYC);
            TY_P10U,
            TY_M10U:  width_of = CW'(W10U_CYC);
            TY_P100U,
            TY_M100U: width_of = CW'(P100U_CYC);
            TY_P1M,
            TY_M1M:   width_of = CW'(P1M_CYC);
            default:  width_of = CW'(W1U_CYC);
        endcase
    endfunction
    // automatic pulse types 2 to 5
    function automatic logic is_auto(input logic [3:0] t);
        is_auto = (t >= TY_P200N) && (t <= TY_P1M);
    endfunction
    // manual pulse types 7 to A
    function automatic logic is_mpul(input logic [3:0] t);
        is_mpul = (t >= TY_M1U) && (t <= TY_M1M);
    endfunction
    // register address matches one of the map entries
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a[1:0] == 2'h0) && (a <= A_ASSIGN);
    endfunction

    logic              aw_ok, w_ok;           // address / data held
    logic [7:0]        wr_addr;               // held write address
    logic [31:0]       wr_data;               // held write data
    logic              wr_do;                 // write performed now
    logic [3:0]        sel_ch;                // addressed channel
    logic [3:0]        ty    [NCH];           // signal type
    logic signed [31:0] st   [NCH];           // start point
    logic signed [31:0] en   [NCH];           // end point
    logic [31:0]       intv  [NCH];           // pulse interval
    logic [NCH-1:0]    armed;                 // preparation state
    logic [NCH-1:0]    in_pass;               // pulse pass under way
    logic signed [31:0] nxt  [NCH];           // next pulse position
    logic signed [31:0] prv  [NCH];           // position a cycle ago
    logic [NCH-1:0]    lvl;                   // gate / manual level
    logic [NCH-1:0]    trig;                  // one-cycle pulse request
    logic              fix_req, fix_eff;      // routing request, in force
    logic [15:0]       assign_r;              // port channel assignment
    logic [NPORT-1:0]  busy;                  // port one-shots running
    logic              cmd_arm, cmd_dis;      // decoded commands
    logic [15:0]       next_assign;           // assignment after write
    logic              dup;                   // duplicate in next_assign

    assign wr_do   = aw_ok && w_ok && !S_AXI_BVALID;
    assign cmd_arm = wr_do && wr_addr == A_CMD && wr_data[CMD_ARM];
    assign cmd_dis = wr_do && wr_addr == A_CMD && wr_data[CMD_DISARM];

    // write channel: take address and data in either order, then answer
    always_ff @(posedge SYS_CLK_I) begin
        if (!RESETN_I) begin
            aw_ok <= 1'b0;
            w_ok <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 32'h0000_0000;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= 2'h0;
        end else begin
            S_AXI_AWREADY <= S_AXI_AWVALID && !S_AXI_AWREADY && !aw_ok;
            S_AXI_WREADY <= S_AXI_WVALID && !S_AXI_WREADY && !w_ok;
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_ok <= 1'b1;
                wr_addr <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_ok <= 1'b1;
                wr_data <= S_AXI_WDATA;
            end
            if (wr_do) begin
                // both halves in: answer, slverr on unmapped address
                aw_ok <= 1'b0;
                w_ok <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= mapped(wr_addr) ? 2'h0 : 2'h2;
            end else if (S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    // read channel: one read at a time, data from a register
    always_ff @(posedge SYS_CLK_I) begin
        if (!RESETN_I) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h0000_0000;
            S_AXI_RRESP <= 2'h0;
        end else begin
            S_AXI_ARREADY <= S_AXI_ARVALID && !S_AXI_ARREADY
                             && !S_AXI_RVALID;
            if (S_AXI_ARVALID && S_AXI_ARREADY) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RRESP <= mapped(S_AXI_ARADDR) ? 2'h0 : 2'h2;
                case (S_AXI_ARADDR)
                    A_CH_SEL: S_AXI_RDATA <= {28'h0, sel_ch};
                    A_TYPE:   S_AXI_RDATA <= {28'h0, ty[sel_ch]};
                    A_START:  S_AXI_RDATA <= st[sel_ch];
                    A_END:    S_AXI_RDATA <= en[sel_ch];
                    A_INTV:   S_AXI_RDATA <= intv[sel_ch];
                    // prep state: auto yes/no, manual level or pulse
                    A_PREP: begin
                        if (ty[sel_ch] == TY_MLVL) begin
                            S_AXI_RDATA <= {29'h0, lvl[sel_ch] ?
                                           PS_HIGH : PS_LOW};
                        end else if (is_mpul(ty[sel_ch])) begin
                            S_AXI_RDATA <= {29'h0, PS_PULSE};
                        end else begin
                            S_AXI_RDATA <= {29'h0, armed[sel_ch] ?
                                           PS_YES : PS_NO};
                        end
                    end
                    // mode in force and request
                    A_ROUTE:  S_AXI_RDATA <= {30'h0, fix_eff, fix_req};
                    A_ASSIGN: S_AXI_RDATA <= {16'h0, assign_r};
                    default:  S_AXI_RDATA <= 32'h0000_0000;
                endcase
            end else if (S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end

    // a write that would repeat a channel on two ports
    always_comb begin
        next_assign = assign_r;
        if (wr_data[3:0] != 4'h0 || S_AXI_WSTRB != 4'h0) begin
            next_assign = wr_data[15:0];
        end
        dup = 1'b0;
        for (int i = 0; i < NPORT; i++) begin
            for (int j = i + 1; j < NPORT; j++) begin
                if (next_assign[i*4+:4] == next_assign[j*4+:4]) begin
                    dup = 1'b1;
                end
            end
        end
    end

    // global settings: channel select, routing, assignments
    always_ff @(posedge SYS_CLK_I) begin
        if (!RESETN_I) begin
            sel_ch <= 4'h0;
            fix_req <= 1'b0;
            fix_eff <= 1'b0;
            assign_r <= RST_ASSIGN;
        end else begin
            if (wr_do && wr_addr == A_CH_SEL) begin
                sel_ch <= wr_data[3:0];
            end
            if (wr_do && wr_addr == A_ROUTE) begin
                fix_req <= wr_data[RT_FIXED];
            end
            if (MOTOR_BUSY_I == '0) begin
                fix_eff <= fix_req;
            end
            if (wr_do && wr_addr == A_ASSIGN && !dup) begin
                assign_r <= next_assign;
            end
        end
    end

    // per-channel settings, arm state and position tracking
    always_ff @(posedge SYS_CLK_I) begin
        if (!RESETN_I) begin
            for (int c = 0; c < NCH; c++) begin
                ty[c] <= TY_NONE;
                st[c] <= RST_START;
                en[c] <= RST_END;
                intv[c] <= RST_INTV;
                nxt[c] <= 32'sh0;
                prv[c] <= 32'sh0;
            end
            armed <= '0;
            in_pass <= '0;
            lvl <= '0;
            trig <= '0;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                automatic logic signed [31:0] p = MOTOR_POS_I[c*32+:32];
                automatic logic cw = en[c] > st[c];
                automatic logic fwd = cw ? p >= prv[c] : p <= prv[c];
                automatic logic hit = cw ? p >= nxt[c] : p <= nxt[c];
                automatic logic inr = cw ? nxt[c] <= en[c]
                                         : nxt[c] >= en[c];
                automatic logic lo = cw ? p >= st[c] : p >= en[c];
                automatic logic hi = cw ? p <= en[c] : p <= st[c];
                automatic logic sel = c == 32'(sel_ch);
                prv[c] <= p;
                trig[c] <= 1'b0;
                if (sel && wr_do && wr_addr == A_TYPE) begin
                    ty[c] <= wr_data[3:0];
                end
                if (sel && wr_do && wr_addr == A_START) begin
                    st[c] <= wr_data;
                end
                if (sel && wr_do && wr_addr == A_END) begin
                    en[c] <= wr_data;
                end
                if (sel && wr_do && wr_addr == A_INTV
                    && wr_data != 32'h0) begin
                    intv[c] <= wr_data;
                end
                // gate or manual level
                lvl[c] <= (armed[c] && ty[c] == TY_GATE && lo && hi)
                          || (armed[c] && ty[c] == TY_MLVL);
                if (sel && cmd_dis) begin
                    // disarm wins over arm and ends any pass
                    armed[c] <= 1'b0;
                    in_pass[c] <= 1'b0;
                end else if (sel && cmd_arm) begin
                    if (is_mpul(ty[c])) begin
                        trig[c] <= 1'b1;
                    end else begin
                        armed[c] <= 1'b1;
                        in_pass[c] <= 1'b0;
                    end
                end else if (armed[c] && is_auto(ty[c])) begin
                    if (!in_pass[c]) begin
                        // first pulse when crossing the start point
                        if (cw ? (prv[c] < st[c] && p >= st[c])
                               : (prv[c] > st[c] && p <= st[c])) begin
                            trig[c] <= 1'b1;
                            in_pass[c] <= 1'b1;
                            nxt[c] <= cw ? st[c] + $signed(intv[c])
                                         : st[c] - $signed(intv[c]);
                        end
                    end else if (!inr && !hi) begin
                        // past the end: pass done, one shot per arming
                        armed[c] <= 1'b0;
                        in_pass[c] <= 1'b0;
                    end else if (fwd && hit && inr) begin
                        // passed points stay spent across stops
                        trig[c] <= 1'b1;
                        nxt[c] <= cw ? nxt[c] + $signed(intv[c])
                                     : nxt[c] - $signed(intv[c]);
                    end
                end
            end
        end
    end

    // output ports: route a channel, stretch its pulses, add its level
    for (genvar gp = 0; gp < NPORT; gp++) begin : g_port
        logic [3:0] src;                              // routed channel
        assign src = fix_eff ? assign_r[gp*4+:4]
                             : DISP_CH_I[gp*4+:4];

        pts_oneshot #(
            .CW      (CW)
        ) u_shot (
            .clk_i   (SYS_CLK_I),
            .rst_n_i (RESETN_I),
            .load_i  (trig[src]),
            .cnt_i   (width_of(ty[src])),
            .busy_o  (busy[gp])
        );

        // registered port drive
        always_ff @(posedge SYS_CLK_I) begin
            if (!RESETN_I) begin
                TIMING_PORT_O[gp] <= 1'b0;
            end else begin
                TIMING_PORT_O[gp] <= lvl[src] || busy[gp];
            end
        end
    end

    a_disarm_clear: assert property (@(posedge SYS_CLK_I)
        disable iff (!RESETN_I)
        cmd_dis |=> !armed[$past(sel_ch)])
        else $error("disarm did not clear the arm state");
    a_arm_set: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
        cmd_arm && !cmd_dis && !is_mpul(ty[sel_ch])
        |=> armed[$past(sel_ch)])
        else $error("arm command did not set the arm state");
    a_pass_once: assert property (@(posedge SYS_CLK_I)
        disable iff (!RESETN_I)
        $fell(in_pass[2]) |-> !armed[2])
        else $error("pulse pass ended while still armed");
    a_no_reverse: assert property (@(posedge SYS_CLK_I)
        disable iff (!RESETN_I)
        !cmd_arm && en[2] > st[2]
        && $signed(MOTOR_POS_I[95:64]) < prv[2] |=> !trig[2])
        else $error("pulse emitted on reverse movement");
    a_manual_lvl: assert property (@(posedge SYS_CLK_I)
        disable iff (!RESETN_I)
        armed[0] && ty[0] == TY_MLVL |=> lvl[0])
        else $error("manual level not driven high");
    a_route_idle: assert property (@(posedge SYS_CLK_I)
        disable iff (!RESETN_I)
        $changed(fix_eff) |-> $past(MOTOR_BUSY_I) == '0)
        else $error("routing changed while a motor moved");
    a_gate_out: assert property (@(posedge SYS_CLK_I)
        disable iff (!RESETN_I)
        lvl[0] && !fix_eff && DISP_CH_I[3:0] == 4'h0
        && $stable(DISP_CH_I) |=> TIMING_PORT_O[0])
        else $error("routed level missing on port zero");
    a_no_dup: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
        wr_do && wr_addr == A_ASSIGN && dup |=> $stable(assign_r))
        else $error("duplicate port assignment accepted");
    c_gate: cover property (@(posedge SYS_CLK_I) $rose(lvl[0]));
    c_pass: cover property (@(posedge SYS_CLK_I) $fell(in_pass[2]));
    c_fixed: cover property (@(posedge SYS_CLK_I) $rose(fix_eff));
endmodule // pts_timing_out
`default_nettype wire

// file: tb/pts_instr_model.sv
/* instrument model: counts rising edges a port, times last high run.
   assumes ports are sampled on the system clock. */
`timescale 1ns/100ps
`default_nettype none
module pts_instr_model (
    input  wire logic        clk_i,   // sampling clock
    input  wire logic [3:0]  port_i,  // timing ports
    output var  logic [31:0] rises_o, // 8-bit count a port
    output var  logic [31:0] width_o  // last high run, cycles
);
    logic [3:0]  last  = '0;          // previous levels
    logic [31:0] run   = '0;          // current high run
    logic [31:0] rises = '0;
    logic [31:0] width = '0;
    // count edges and time the pulse seen on any port
    always @(posedge clk_i) begin
        for (int p = 0; p < 4; p++)
            if (port_i[p] && !last[p]) rises[p*8+:8] <= rises[p*8+:8] + 8'h01;
        run <= (|port_i) ? run + 32'h1 : '0;
        if (!(|port_i) && (|last)) width <= run;
        last <= port_i;
    end
    assign rises_o = rises;
    assign width_o = width;
endmodule // pts_instr_model
`default_nettype wire

// file: tb/position_timing_signal_output_tb.sv
/* bench for the timing output block, driven over AXI4-Lite.
   assumes a 200 MHz clock and shortened long pulse counts. */
`timescale 1ns/100ps
`default_nettype none
module position_timing_signal_output_tb import pts_pkg::*;;
    logic clk = 0, rn = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
    logic awr, wr, bv, arr, rv;                // slave answers
    logic [7:0]  aw = '0, ar = '0;              // addresses
    logic [31:0] wd = '0, rd, rs, wi;           // data, rises, width
    logic [1:0]  bresp, rresp;
    logic [511:0] pos = '0;                     // motor positions
    logic [15:0] busy = '0;                     // motors moving
    logic [15:0] disp = 16'h3210;               // channel at each row
    logic [3:0]  tp;                            // timing ports
    logic [31:0] d;                             // read result
    int num_errors = 0, compares = 0, cyc = 0;
    always #2.5 clk = ~clk;
    pts_timing_out #(.P100U_CYC(300), .P1M_CYC(600)) dut_u (.SYS_CLK_I(clk),
        .RESETN_I(rn), .MOTOR_POS_I(pos), .MOTOR_BUSY_I(busy),
        .DISP_CH_I(disp), .TIMING_PORT_O(tp), .S_AXI_AWVALID(awv),
        .S_AXI_AWREADY(awr), .S_AXI_AWADDR(aw), .S_AXI_WVALID(wv),
        .S_AXI_WREADY(wr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF),
        .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_BRESP(bresp),
        .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ar),
        .S_AXI_RVALID(rv), .S_AXI_RREADY(rr), .S_AXI_RDATA(rd),
        .S_AXI_RRESP(rresp));
    pts_instr_model inst_u (.clk_i(clk), .port_i(tp), .rises_o(rs),
        .width_o(wi));
    // compare and report
    task chk(input string n, input logic [31:0] e, input logic [31:0] s);
        compares++;
        if (s !== e) begin
            num_errors++;
            $display("[FAIL] %s exp %h got %h", n, e, s);
        end
    endtask
    // one write, each channel released when taken
    task wrt(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        awv <= 1; wv <= 1; aw <= a; wd <= v; br <= 1;
        do begin
            @(posedge clk);
            if (awr) awv <= 0;
            if (wr) wv <= 0;
        end while (!bv);
        br <= 0;
    endtask
    // one read, data taken with rvalid
    task rdr(input logic [7:0] a);
        @(posedge clk);
        arv <= 1; ar <= a; rr <= 1;
        do begin
            @(posedge clk);
            if (arr) arv <= 0;
        end while (!rv);
        d = rd;
        rr <= 0;
    endtask
    task wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    task t_reset;
        rdr(A_PREP);   chk("prep", PS_NO, d);
        rdr(A_ROUTE);  chk("route", 32'h0, d);
        rdr(A_ASSIGN); chk("assign", 32'h3210, d);
        rdr(A_INTV);   chk("intv", 32'hC8, d);
        rdr(8'h40);    chk("unmapped", 32'h2, rresp);
    endtask
    task t_manual;
        wrt(A_TYPE, TY_MLVL); wrt(A_CMD, 32'h1); wt(4);
        chk("lvl hi", 1, tp[0]);
        rdr(A_PREP); chk("prep hi", PS_HIGH, d);
        wrt(A_CMD, 32'h2); wt(4); chk("lvl lo", 0, tp[0]);
        wrt(A_TYPE, TY_M1U); wrt(A_CMD, 32'h1); wt(260);
        chk("mp width", W1U_CYC, wi);
        chk("mp count", 32'h2, rs);
        rdr(A_PREP); chk("prep pulse", PS_PULSE, d);
    endtask
    task t_gate;
        wrt(A_CH_SEL, 1); wrt(A_TYPE, TY_GATE); wrt(A_CMD, 1);
        pos[63:32] <= 500; wt(5); chk("gate out", 0, tp[1]);
        pos[63:32] <= 2000; wt(5); chk("gate in", 1, tp[1]);
        wrt(A_CMD, 2); wt(5); chk("gate off", 0, tp[1]);
    endtask
    task t_pulse;
        wrt(A_CH_SEL, 2); wrt(A_TYPE, TY_P200N); pos[95:64] <= 900;
        wrt(A_CMD, 1); pos[95:64] <= 1000; wt(60);
        chk("start pulse", 32'h10102, rs);
        chk("auto width", W200N_CYC, wi);
        pos[95:64] <= 800; wt(60);
        chk("reverse", 32'h10102, rs);
        pos[95:64] <= 1250; wt(60);
        chk("resume", 32'h20102, rs);
        pos[95:64] <= 10400; wt(150);
        chk("pass end", 32'h30102, rs);
        rdr(A_PREP); chk("pass disarm", PS_NO, d);
        pos[95:64] <= 900; wrt(A_CMD, 1); pos[95:64] <= 1000; wt(60);
        chk("rearm", 32'h40102, rs);
        wrt(A_CMD, 2); pos[95:64] <= 1300; wt(60);
        chk("disarmed stop", 32'h40102, rs);
    endtask
    task t_route;
        busy <= 16'h1; wrt(A_ROUTE, 1); rdr(A_ROUTE);
        chk("route busy", 32'h1, d);
        busy <= 0; wt(3); rdr(A_ROUTE);
        chk("route fixed", 32'h3, d);
        wrt(A_ASSIGN, 32'h0123); wrt(A_ASSIGN, 32'h1123); rdr(A_ASSIGN);
        chk("assign dup", 32'h0123, d);
        wrt(A_CH_SEL, 0); wrt(A_TYPE, TY_MLVL); wrt(A_CMD, 1); wt(4);
        chk("fixed port", 32'h8, tp);
        busy <= 16'h4; wrt(A_ROUTE, 0); wt(3);
        chk("route held", 32'h8, tp);
        busy <= 0; wt(4); chk("display port", 32'h1, tp);
        disp <= 16'h0123; wt(4); chk("display row", 32'h8, tp);
    endtask
    task results;
        $display("compares %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // cut a hang short
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            results;
        end
    end
    initial begin
        wt(6); rn <= 1; wt(1);
        t_reset; t_manual; t_gate; t_pulse; t_route;
        results;
    end
endmodule // position_timing_signal_output_tb
`default_nettype wire
